// ---- dram_timing.sv ----
/*
 * main-board timing end: sequences row gate, row strobe, column gate
 * and column strobe per request, and issues refresh cycles.
 * assumes requests held stable until done_o; one clock on both ends.
 */
`default_nettype none
module dram_timing
#(
    parameter int unsigned REFRESH_SPACING =
        dram_board_pkg::REFRESH_SPACING_CYCLES
)
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // processor request
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic [dram_board_pkg::ADDR_W-1:0] req_addr_i,
    input wire logic rom_hit_n_i,
    input wire logic video_memory_hit_n_i,
    input wire logic bank1_enable_i,
    output logic busy_o,
    output logic done_o,
    // connector
    dram_board_if.timing bus
);
    //////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {IDLE, ROW, RAS, COL, CAS, GAP} state_t;
    state_t state_reg;
    state_t state_next;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [15:0] ref_cnt_reg;
    logic [6:0] ref_row_reg;
    logic refresh_reg;
    logic [dram_board_pkg::ADDR_W-1:0] addr_reg;
    logic write_reg;
    wire logic ref_due;
    wire logic ref_want;
    logic refresh_pend_reg;
    wire logic [15:0] access_cnt;
    wire logic [15:0] gap_cnt;

    assign access_cnt = 16'(dram_board_pkg::ACCESS_CYCLES);
    assign gap_cnt = 16'(dram_board_pkg::CYCLE_CYCLES);
    assign ref_due = (ref_cnt_reg == 16'(REFRESH_SPACING - 1));
    // a refresh falling due mid-access waits instead of being lost
    assign ref_want = ref_due || refresh_pend_reg;

    always_comb
    begin
        state_next = state_reg;
        cnt_next = (cnt_reg == 16'h0000) ? 16'h0000 : cnt_reg - 16'h0001;
        case (state_reg)
            IDLE: if (ref_want || req_i) state_next = ROW;
            ROW: state_next = RAS;
            RAS:
            begin
                state_next = refresh_reg ? GAP : COL;
                cnt_next = refresh_reg ? gap_cnt : access_cnt;
            end
            COL: state_next = CAS;
            CAS: if (cnt_reg == 16'h0000)
            begin
                state_next = GAP;
                cnt_next = gap_cnt;
            end
            GAP: if (cnt_reg == 16'h0000) state_next = IDLE;
            default: state_next = IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            state_reg <= IDLE;
            cnt_reg <= 16'h0000;
            ref_cnt_reg <= 16'h0000;
            ref_row_reg <= 7'h00;
            refresh_reg <= 1'b0;
            refresh_pend_reg <= 1'b0;
            addr_reg <= 16'h0000;
            write_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            ref_cnt_reg <= ref_due ? 16'h0000 : ref_cnt_reg + 16'h0001;
            refresh_pend_reg <= (ref_due || refresh_pend_reg) &&
                (state_reg != IDLE);
            if (state_reg == IDLE && (ref_want || req_i))
            begin
                refresh_reg <= ref_want;
                // high lines keep the last address so line 7 does not toggle
                addr_reg <= ref_want ? {addr_reg[15:7], ref_row_reg} :
                    req_addr_i;
                write_reg <= !ref_want && req_write_i;
            end
            if (state_reg == GAP && state_next == IDLE && refresh_reg)
                ref_row_reg <= ref_row_reg + 7'h01;
        end
    end

    //////////////////////////////////////////////////////////////////
    wire logic in_cycle;
    assign in_cycle = (state_reg != IDLE);
    assign busy_o = in_cycle;
    assign done_o = (state_reg == GAP) && (cnt_reg == 16'h0000) &&
        !refresh_reg;
    assign bus.cpu_addr = addr_reg;
    assign bus.read_n = !(in_cycle && !write_reg);
    assign bus.rom_hit_n = rom_hit_n_i;
    assign bus.video_memory_hit_n = video_memory_hit_n_i;
    assign bus.bank1_enable = bank1_enable_i;
    assign bus.refresh_cycle_n = !(in_cycle && refresh_reg);
    assign bus.row_half_gate_n = !(state_reg == ROW || state_reg == RAS);
    assign bus.column_half_gate_n = !(state_reg == COL || state_reg == CAS);
    assign bus.row_strobe_n = !(state_reg == RAS || state_reg == COL ||
        state_reg == CAS);
    assign bus.column_strobe_n = !(state_reg == CAS && !refresh_reg);
endmodule
`default_nettype wire

// ---- dram_board_pkg.sv ----
/*
 * constants shared by the banked dynamic memory board and its main-board
 * partner: address split, bank decode value and cycle timing.
 * assumes a single 20 MHz clock on both ends.
 */
`default_nettype none
package dram_board_pkg;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned ACCESS_TIME_NS = 200;
    localparam int unsigned CYCLE_TIME_NS = 335;
    localparam int unsigned REFRESH_PERIOD_MS = 2;
    localparam int unsigned REFRESH_ROWS = 128;
    // least times round up
    localparam int unsigned ACCESS_CYCLES =
        (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYCLE_CYCLES =
        (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // longest time rounds down
    localparam int unsigned REFRESH_PERIOD_CYCLES =
        REFRESH_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned REFRESH_SPACING_CYCLES =
        REFRESH_PERIOD_CYCLES / REFRESH_ROWS;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned HALF_W = 8;
    localparam int unsigned ROW_LSB = 0;
    localparam int unsigned COL_LSB = 8;
    localparam int unsigned REFRESH_BLOCK_BIT = 7;
    localparam int unsigned HIGH_NIBBLE_LSB = 12;
    localparam logic [3:0] TOP_NIBBLE = 4'hF;
    localparam int unsigned BANKS = 2;
endpackage
`default_nettype wire

// ---- dram_board_if.sv ----
/*
 * connector between main-board timing network and the memory board.
 * assumes both ends share ref_clk_i; active-low strobes idle high.
 */
`default_nettype none
interface dram_board_if;
    logic [dram_board_pkg::ADDR_W-1:0] cpu_addr;
    logic read_n;
    logic rom_hit_n;
    logic video_memory_hit_n;
    logic bank1_enable;
    logic refresh_cycle_n;
    logic row_half_gate_n;
    logic column_half_gate_n;
    logic row_strobe_n;
    logic column_strobe_n;

    modport board
    (
        input cpu_addr, read_n, rom_hit_n, video_memory_hit_n,
        input bank1_enable, refresh_cycle_n, row_half_gate_n,
        input column_half_gate_n, row_strobe_n, column_strobe_n
    );
    modport timing
    (
        output cpu_addr, read_n, rom_hit_n, video_memory_hit_n,
        output bank1_enable, refresh_cycle_n, row_half_gate_n,
        output column_half_gate_n, row_strobe_n, column_strobe_n
    );
endinterface
`default_nettype wire

// ---- dram_board.sv ----
/*
 * memory board end: address multiplexing, bank steering of row and
 * column strobes, write enable capture and refresh handling.
 * assumes the timing end orders gates and strobes and supplies refresh
 * row addresses; inputs synchronous to ref_clk_i.
 */
`default_nettype none
module dram_board
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // main-board connector
    dram_board_if.board bus,
    // memory chip side
    output logic [dram_board_pkg::HALF_W-1:0] mem_addr_o,
    output logic [dram_board_pkg::BANKS-1:0] row_strobe_n_o,
    output logic [dram_board_pkg::BANKS-1:0] column_strobe_n_o,
    output logic [dram_board_pkg::BANKS-1:0] write_enable_n_o,
    output logic [dram_board_pkg::BANKS-1:0] data_in_en_o,
    output logic [dram_board_pkg::BANKS-1:0] data_out_en_o
);
    //////////////////////////////////////////////////////////////////
    wire logic [3:0] high_nibble;
    wire logic top_hit;
    wire logic decode_free;
    wire logic [dram_board_pkg::BANKS-1:0] bank_sel;
    wire logic refreshing;
    wire logic [dram_board_pkg::HALF_W-1:0] row_half;
    wire logic [dram_board_pkg::HALF_W-1:0] col_half;
    wire logic [dram_board_pkg::HALF_W-1:0] addr_next;
    wire logic row_fall;
    logic row_strobe_d_reg;
    logic write_reg;
    logic [dram_board_pkg::HALF_W-1:0] addr_reg;

    assign high_nibble =
        bus.cpu_addr[dram_board_pkg::HIGH_NIBBLE_LSB +: 4];
    assign top_hit = (high_nibble == dram_board_pkg::TOP_NIBBLE);
    assign decode_free = bus.rom_hit_n && bus.video_memory_hit_n;
    assign bank_sel[0] = decode_free && (!bus.bank1_enable || top_hit);
    assign bank_sel[1] = decode_free && !top_hit && bus.bank1_enable;
    assign refreshing = !bus.refresh_cycle_n;

    //////////////////////////////////////////////////////////////////
    // row half is low byte with line 7 blocked during refresh
    assign row_half =
        {bus.cpu_addr[dram_board_pkg::REFRESH_BLOCK_BIT] && !refreshing,
         bus.cpu_addr[dram_board_pkg::REFRESH_BLOCK_BIT-1:0]};
    assign col_half =
        bus.cpu_addr[dram_board_pkg::COL_LSB +: dram_board_pkg::HALF_W];
    // row gate has priority so row address wins if both gates low
    assign addr_next = !bus.row_half_gate_n ? row_half :
        (!bus.column_half_gate_n ? col_half : addr_reg);

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            addr_reg <= 8'h00;
        else
            addr_reg <= addr_next;
    end
    assign mem_addr_o = addr_reg;

    //////////////////////////////////////////////////////////////////
    // write flag caught on falling row strobe
    assign row_fall = row_strobe_d_reg && !bus.row_strobe_n;
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            row_strobe_d_reg <= 1'b1;
            write_reg <= 1'b0;
        end
        else
        begin
            row_strobe_d_reg <= bus.row_strobe_n;
            if (row_fall)
                write_reg <= bus.read_n;
        end
    end

    //////////////////////////////////////////////////////////////////
    genvar b;
    generate
        for (b = 0; b < dram_board_pkg::BANKS; b++)
        begin : g_bank
            wire logic col_on;
            assign col_on = bank_sel[b] && !bus.column_strobe_n &&
                !refreshing;
            assign row_strobe_n_o[b] =
                !(bank_sel[b] && !bus.row_strobe_n);
            assign column_strobe_n_o[b] = !col_on;
            // flag is only current once the row strobe edge has passed
            assign write_enable_n_o[b] = !(bank_sel[b] && write_reg &&
                !bus.row_strobe_n && !row_strobe_d_reg);
            assign data_in_en_o[b] = col_on && write_reg;
            assign data_out_en_o[b] = col_on && !write_reg;
        end
    endgenerate
endmodule
`default_nettype wire

// ---- dram_board_sva.sv ----
/* checks on the board connector and chip-side outputs.
   assumes one clock and a synchronous active-high reset. */
`default_nettype none
module dram_board_sva
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // connector
    input wire logic [15:0] cpu_addr,
    input wire logic read_n,
    input wire logic rom_hit_n,
    input wire logic video_memory_hit_n,
    input wire logic bank1_enable,
    input wire logic refresh_cycle_n,
    input wire logic row_half_gate_n,
    input wire logic column_half_gate_n,
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    // chip side
    input wire logic [7:0] mem_addr_o,
    input wire logic [1:0] row_strobe_n_o,
    input wire logic [1:0] column_strobe_n_o,
    input wire logic [1:0] write_enable_n_o,
    input wire logic [1:0] data_in_en_o,
    input wire logic [1:0] data_out_en_o
);
    wire logic free = rom_hit_n & video_memory_hit_n;
    wire logic top_f = cpu_addr[15:12] == 4'hF;
    wire logic [1:0] sel = {free & bank1_enable & !top_f,
        free & (!bank1_enable | top_f)};
    wire logic cas_ok = refresh_cycle_n & !column_strobe_n;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);
    ////////////////////////////////////////////////////////////////////
    sequence s_ras_fall;
        $fell(row_strobe_n);
    endsequence
    sequence s_row_take;
        !row_half_gate_n;
    endsequence
    sequence s_col_take;
        row_half_gate_n && !column_half_gate_n;
    endsequence
    a_row_low_byte: assert property (s_row_take ##0 refresh_cycle_n
        |=> mem_addr_o == $past(cpu_addr[7:0])) else $error("row half bad");
    a_col_high_byte: assert property (s_col_take
        |=> mem_addr_o == $past(cpu_addr[15:8])) else $error("col half bad");
    a_refresh_bit_seven: assert property (s_row_take ##0 !refresh_cycle_n
        |=> mem_addr_o == {1'b0, $past(cpu_addr[6:0])})
        else $error("refresh row bad");
    a_gate_order: assert property ($fell(column_half_gate_n)
        |-> $past(row_half_gate_n, 2) == 1'b0) else $error("gate order");
    a_bank_steer: assert property (row_strobe_n_o == ~(sel & {2{!row_strobe_n}})
        && column_strobe_n_o == ~(sel & {2{cas_ok}}))
        else $error("strobe steering");
    a_refresh_quiet: assert property (!refresh_cycle_n |->
        column_strobe_n_o == 2'b11 && (data_in_en_o | data_out_en_o) == 2'b00)
        else $error("refresh not quiet");
    a_data_path: assert property ((data_in_en_o | data_out_en_o)
        == ~column_strobe_n_o) else $error("data path enable");
    a_write_capture: assert property (s_ras_fall |=> write_enable_n_o
        == ($past(read_n) ? row_strobe_n_o : 2'b11)) else $error("write enable");
    a_cas_width: assert property ($fell(column_strobe_n)
        |-> !column_strobe_n [*4] ##1 column_strobe_n)
        else $error("column strobe width");
    a_write_held: assert property (s_ras_fall
        |-> write_enable_n_o == 2'b11) else $error("write enable early");
endmodule
`default_nettype wire

// ---- test_banked_dram_board_control.sv ----
/* bench joining the timing end and the board end.
   assumes the connector interface and the constants package. */
`default_nettype none
module test_banked_dram_board_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic req = 1'b0, req_write = 1'b0, rom_n = 1'b1, vid_n = 1'b1;
    logic b1 = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic done;
    logic [7:0] mem_addr;
    logic [1:0] rs_n, cs_n, we_n, din, dout;
    int failures = 0, compares = 0, seen_rf = 0;
    dram_board_if bus_if();
    always #25 ref_clk = ~ref_clk;
    dram_timing #(.REFRESH_SPACING(40)) dram_timing_inst (.ref_clk_i(ref_clk),
        .reset_i(reset), .req_i(req), .req_write_i(req_write),
        .req_addr_i(addr), .rom_hit_n_i(rom_n), .video_memory_hit_n_i(vid_n),
        .bank1_enable_i(b1), .busy_o(), .done_o(done), .bus(bus_if));
    dram_board dram_board_inst (.ref_clk_i(ref_clk), .reset_i(reset),
        .bus(bus_if), .mem_addr_o(mem_addr), .row_strobe_n_o(rs_n),
        .column_strobe_n_o(cs_n), .write_enable_n_o(we_n),
        .data_in_en_o(din), .data_out_en_o(dout));
    dram_board_sva dram_board_sva_inst (.ref_clk_i(ref_clk), .reset_i(reset),
        .cpu_addr(bus_if.cpu_addr), .read_n(bus_if.read_n),
        .rom_hit_n(bus_if.rom_hit_n),
        .video_memory_hit_n(bus_if.video_memory_hit_n),
        .bank1_enable(bus_if.bank1_enable),
        .refresh_cycle_n(bus_if.refresh_cycle_n),
        .row_half_gate_n(bus_if.row_half_gate_n),
        .column_half_gate_n(bus_if.column_half_gate_n),
        .row_strobe_n(bus_if.row_strobe_n),
        .column_strobe_n(bus_if.column_strobe_n), .mem_addr_o(mem_addr),
        .row_strobe_n_o(rs_n), .column_strobe_n_o(cs_n),
        .write_enable_n_o(we_n), .data_in_en_o(din), .data_out_en_o(dout));
    ////////////////////////////////////////////////////////////////////
    function automatic logic [1:0] bank_sel(input logic [15:0] a,
        input logic r, v, e);
        logic f;
        logic t;
        f = r & v;
        t = a[15:12] == dram_board_pkg::TOP_NIBBLE;
        return {f & e & !t, f & (!e | t)};
    endfunction
    task automatic check(input string name, input logic [9:0] seen, exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // one request; strobes and enables gathered outside refresh cycles
    task automatic access(input logic [15:0] a, input logic w, r, v, e);
        logic [1:0] s, rs, cs, we, di, dq;
        logic [7:0] ra, ca;
        logic r7;
        int n;
        s = bank_sel(a, r, v, e);
        {rs, cs, we, di, dq} = 10'h000;
        n = 0;
        ra = ~a[7:0];
        ca = ~a[15:8];
        r7 = 1'b0;
        @(posedge ref_clk);
        req <= 1'b1;
        req_write <= w;
        addr <= a;
        rom_n <= r;
        vid_n <= v;
        b1 <= e;
        while (n < 200)
        begin
            @(negedge ref_clk);
            n++;
            if (bus_if.refresh_cycle_n === 1'b1)
            begin
                {rs, cs, we, di, dq} |= ~{rs_n, cs_n, we_n, ~din, ~dout};
                if (bus_if.column_half_gate_n === 1'b0 &&
                    bus_if.column_strobe_n === 1'b1)
                    ra = mem_addr;
                if (bus_if.column_strobe_n === 1'b0)
                    ca = mem_addr;
            end
            else if (bus_if.row_half_gate_n === 1'b1)
                r7 |= mem_addr[7];
            if (done === 1'b1)
                break;
        end
        if (n == 200)
            failures++;
        @(posedge ref_clk);
        req <= 1'b0;
        check("bank strobes", {rs, cs, we, di, dq}, {s, s, w ? s : 2'b00,
            w ? s : 2'b00, w ? 2'b00 : s});
        check("row half", {2'b00, ra}, {2'b00, a[7:0]});
        check("column half", {2'b00, ca}, {2'b00, a[15:8]});
        check("refresh bit seven", {9'h000, r7}, 10'h000);
    endtask
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        end_of_test;
    end
    initial
    begin
        void'($urandom(20944));
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        @(negedge ref_clk);
        check("idle strobes", {6'h00, rs_n, cs_n}, 10'h00F);
        for (int i = 0; i < 32; i++)
            access(i[0] ? 16'hF0A5 : 16'hE15A, i[1], i[2], i[3], i[4]);
        $display("test corners done");
        repeat (40)
            access(16'($urandom), 1'($urandom), $urandom_range(3) != 0,
                $urandom_range(3) != 0, 1'($urandom));
        $display("test random done");
        repeat (100)
        begin
            @(negedge ref_clk);
            if (bus_if.refresh_cycle_n === 1'b0)
                seen_rf++;
        end
        check("refresh seen", {9'h000, seen_rf > 0}, 10'h001);
        $display("test refresh done");
        end_of_test;
    end
endmodule
`default_nettype wire
